// >>> src/load_divider_pkg.sv
// Constants shared by the video DAC clock and load divider.
// Assumes one free-running oscillator clock at 100 MHz drives the whole block.
package load_divider_pkg;

	// Divide-select codes, with the most significant pin first.
	localparam logic [1:0] SEL_DIV3 = 2'h0;
	localparam logic [1:0] SEL_DIV4 = 2'h1;
	localparam logic [1:0] SEL_DIV5 = 2'h2;
	localparam logic [1:0] SEL_DIV8 = 2'h3;
	localparam logic [1:0] SEL_RESET = SEL_DIV4;

	// Clock cycles low and high of one primary load period.
	localparam logic [2:0] DIV3_LOW = 3'h1;
	localparam logic [2:0] DIV3_HIGH = 3'h2;
	localparam logic [2:0] DIV4_LOW = 3'h2;
	localparam logic [2:0] DIV4_HIGH = 3'h2;
	localparam logic [2:0] DIV5_LOW = 3'h2;
	localparam logic [2:0] DIV5_HIGH = 3'h3;
	localparam logic [2:0] DIV8_LOW = 3'h4;
	localparam logic [2:0] DIV8_HIGH = 3'h4;

	// Number of synchronised input pins and their positions.
	localparam int SYNC_W = 4;
	localparam int POS_SEL_LSB = 0;
	localparam int POS_SEL_MSB = 1;
	localparam int POS_ENABLE_S = 2;
	localparam int POS_PIPE_RESET = 3;
	// Idle levels of the synchronised pins; the pipeline reset pin idles high.
	// Starting from the idle level keeps reset release from looking like a pin edge.
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 4'h8;

	// Pipeline reset sequencer states.
	typedef enum logic [2:0] {
		PIPE_IDLE = 3'h1,
		PIPE_ARMED = 3'h2,
		PIPE_HALTED = 3'h4
	} pipe_state_t;

	function automatic logic [2:0] low_of(input logic [1:0] sel);
		case (sel)
			SEL_DIV3: low_of = DIV3_LOW;
			SEL_DIV4: low_of = DIV4_LOW;
			SEL_DIV5: low_of = DIV5_LOW;
			default: low_of = DIV8_LOW;
		endcase
	endfunction

	function automatic logic [2:0] high_of(input logic [1:0] sel);
		case (sel)
			SEL_DIV3: high_of = DIV3_HIGH;
			SEL_DIV4: high_of = DIV4_HIGH;
			SEL_DIV5: high_of = DIV5_HIGH;
			default: high_of = DIV8_HIGH;
		endcase
	endfunction

endpackage

// >>> src/pin_sync.sv
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stage1_q <= RESET_VALUE;
			stage2_q <= RESET_VALUE;
		end
		else
		begin
			stage1_q <= async_in;
			stage2_q <= stage1_q;
		end
	end

	assign sync_out = stage2_q;

endmodule

`default_nettype wire

// >>> src/video_dac_clock_load_divider.sv
// Pixel clock and load strobe generator for a video palette DAC.
// Assumes clk is the oscillator itself; all other inputs are asynchronous pins.
//
// Overview of operation
// - The select pins pick a ratio of 3, 4, 5 or 8, low/high 1/2, 2/2, 2/3 or 4/4 clocks.
// - The pixel clock pair runs at the oscillator rate with its two outputs complementary.
// - Both primary load outputs divide the pixel clock by the chosen ratio and are identical.
// - The half-rate load toggles on each primary load rise, so its period is two load periods.
// - The quarter-rate load output has a period of four primary load periods.
// - The sync gate is timed to the primary load; while it is low both gated loads are zero.
// - The async gate low freezes the gated loads at their level from its fall, with no clock.
// - With both gates high the gated loads match the primary loads in timing and phase.
// - After a pipeline reset rise the next quarter-rate rise stops the clock pair, true high.
// - A halted clock pair resumes free running at the following quarter-rate rise.
// - The pipeline reset pin is edge triggered here and its driver keeps it glitch free.
// - The halt fixes the downstream pipeline delay, whose count the downstream DAC defines.
`timescale 1ns/100ps
`default_nettype none

module video_dac_clock_load_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic divide_select_lsb,
	input wire logic divide_select_msb,
	input wire logic enable_sync,
	input wire logic enable_async,
	input wire logic pipe_reset_n,
	output logic pixel_clock_p,
	output logic pixel_clock_n,
	output logic load_primary_a,
	output logic load_primary_b,
	output logic load_half_rate,
	output logic load_quarter_rate,
	output logic load_gated_c,
	output logic load_gated_d
);

	logic [load_divider_pkg::SYNC_W-1:0] pins_sync;
	logic [1:0] sel_sync;
	logic [1:0] ratio_q;
	logic [1:0] ratio_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic wrap;
	logic load_q;
	logic load_d;
	logic load_rise;
	logic [1:0] sub_q;
	logic quarter_rise;
	logic gate_q;
	logic gate_d;
	logic gated_live_q;
	logic gated_live_d;
	logic gated_hold_q;
	logic reset_seen_q;
	logic reset_rise;
	load_divider_pkg::pipe_state_t state_q;

	pin_sync #(
		.WIDTH(load_divider_pkg::SYNC_W),
		.RESET_VALUE(load_divider_pkg::SYNC_IDLE)
	) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.async_in({pipe_reset_n, enable_sync, divide_select_msb, divide_select_lsb}),
		.sync_out(pins_sync)
	);

	assign sel_sync = {pins_sync[load_divider_pkg::POS_SEL_MSB],
		pins_sync[load_divider_pkg::POS_SEL_LSB]};

	// A new ratio is only taken at a period boundary, so no load pulse is ever cut short.
	assign wrap = cnt_q == 3'(load_divider_pkg::low_of(ratio_q)
		+ load_divider_pkg::high_of(ratio_q) - 3'h1);
	assign ratio_d = wrap ? sel_sync : ratio_q;
	assign cnt_d = wrap ? 3'h0 : 3'(cnt_q + 3'h1);
	assign load_d = cnt_d >= load_divider_pkg::low_of(ratio_d);
	assign load_rise = load_d && !load_q;
	assign quarter_rise = load_rise && (sub_q == 2'h1);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ratio_q <= load_divider_pkg::SEL_RESET;
			cnt_q <= 3'h0;
			load_q <= 1'b0;
		end
		else
		begin
			ratio_q <= ratio_d;
			cnt_q <= cnt_d;
			load_q <= load_d;
		end
	end

	// Bit 0 is the half-rate load, bit 1 the quarter-rate load.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sub_q <= 2'h0;
		else if (load_rise)
			sub_q <= 2'(sub_q + 2'h1);
	end

	// The synchronous gate is taken only where a load period begins.
	assign gate_d = wrap ? pins_sync[load_divider_pkg::POS_ENABLE_S] : gate_q;
	assign gated_live_d = load_d && gate_d;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gate_q <= 1'b0;
			gated_live_q <= 1'b0;
		end
		else
		begin
			gate_q <= gate_d;
			gated_live_q <= gated_live_d;
		end
	end

	// The hold copy follows the live value only while the asynchronous gate is high.
	// It reads the raw pin on purpose: a synchronised copy would lag the freeze.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gated_hold_q <= 1'b0;
		else if (enable_async)
			gated_hold_q <= gated_live_d;
	end

	// Edge detection sits after the synchroniser, behind a third flop.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			reset_seen_q <= load_divider_pkg::SYNC_IDLE[load_divider_pkg::POS_PIPE_RESET];
		else
			reset_seen_q <= pins_sync[load_divider_pkg::POS_PIPE_RESET];
	end

	assign reset_rise = pins_sync[load_divider_pkg::POS_PIPE_RESET] && !reset_seen_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= load_divider_pkg::PIPE_IDLE;
		else
		begin
			unique case (state_q)
				load_divider_pkg::PIPE_IDLE:
					if (reset_rise)
						state_q <= load_divider_pkg::PIPE_ARMED;
				load_divider_pkg::PIPE_ARMED:
					if (quarter_rise)
						state_q <= load_divider_pkg::PIPE_HALTED;
				load_divider_pkg::PIPE_HALTED:
					if (quarter_rise)
						state_q <= load_divider_pkg::PIPE_IDLE;
				default:
					state_q <= load_divider_pkg::PIPE_IDLE;
			endcase
		end
	end

	// The halt flop only changes on a rising clk edge while clk is high, so the gated
	// clock cannot glitch either when stopping or when restarting.
	assign pixel_clock_p = clk || (state_q == load_divider_pkg::PIPE_HALTED);
	assign pixel_clock_n = !pixel_clock_p;
	assign load_primary_a = load_q;
	assign load_primary_b = load_q;
	assign load_half_rate = sub_q[0];
	assign load_quarter_rate = sub_q[1];
	// Both gates low is outside the contract; the freeze then wins over the gate.
	assign load_gated_c = enable_async ? gated_live_q : gated_hold_q;
	assign load_gated_d = load_gated_c;

	sequence armed_s;
		state_q == load_divider_pkg::PIPE_ARMED;
	endsequence

	sequence halted_s;
		state_q == load_divider_pkg::PIPE_HALTED;
	endsequence

	sequence quarter_up_s;
		$rose(load_quarter_rate);
	endsequence

	a_pair_complement: assert property (@(posedge clk) disable iff (rst)
		pixel_clock_n == !pixel_clock_p)
		else $error("Clock pair outputs are not complementary.");

	a_div3_high: assert property (@(posedge clk) disable iff (rst)
		$rose(load_primary_a) && ratio_q == load_divider_pkg::SEL_DIV3
		|-> load_primary_a [*2] ##1 !load_primary_a)
		else $error("Divide by three high phase is not two clocks.");

	a_div8_low: assert property (@(posedge clk) disable iff (rst)
		$fell(load_primary_a) && ratio_q == load_divider_pkg::SEL_DIV8
		|-> !load_primary_a [*4] ##1 load_primary_a)
		else $error("Divide by eight low phase is not four clocks.");

	a_primary_equal: assert property (@(posedge clk) disable iff (rst)
		load_primary_a == load_primary_b)
		else $error("Primary load outputs differ.");

	a_half_toggle: assert property (@(posedge clk) disable iff (rst)
		$rose(load_primary_a) |-> $changed(load_half_rate))
		else $error("Half-rate load did not toggle on a load rise.");

	a_quarter_phase: assert property (@(posedge clk) disable iff (rst)
		$rose(load_quarter_rate) |-> $rose(load_primary_a) && !load_half_rate)
		else $error("Quarter-rate load rose out of phase.");

	a_sync_gate_zero: assert property (@(posedge clk) disable iff (rst)
		!gate_q && enable_async && $past(enable_async) |-> !load_gated_c)
		else $error("Gated load active while synchronous gate is low.");

	a_gate_boundary: assert property (@(posedge clk) disable iff (rst)
		$changed(gate_q) |-> $fell(load_primary_a))
		else $error("Synchronous gate changed inside a load period.");

	a_async_freeze: assert property (@(posedge clk) disable iff (rst)
		!enable_async && !$past(enable_async) |-> $stable(load_gated_c) && $stable(load_gated_d))
		else $error("Gated load moved while asynchronous gate is low.");

	a_free_run: assert property (@(posedge clk) disable iff (rst)
		gate_q && enable_async && $past(enable_async) |-> load_gated_c == load_primary_a)
		else $error("Gated load does not follow primary load.");

	a_halt_entry: assert property (@(posedge clk) disable iff (rst)
		armed_s ##1 quarter_up_s |-> halted_s and pixel_clock_p)
		else $error("Clock pair did not halt at the quarter-rate rise.");

	a_halt_resume: assert property (@(posedge clk) disable iff (rst)
		halted_s ##1 quarter_up_s |-> state_q == load_divider_pkg::PIPE_IDLE)
		else $error("Clock pair did not resume at the quarter-rate rise.");

endmodule

`default_nettype wire

// >>> verification/dac_side_model.sv
// Stand-in for the downstream DAC and the DRAM shift registers.
// Assumes it sees the divider's positive pixel clock and first gated load.
`timescale 1ns/100ps
`default_nettype none

module dac_side_model (
	input wire logic pixel_clock_p,
	input wire logic load_gated_c,
	output int pixel_edges,
	output int shift_edges
);
	// Counting edges shows stalls that a level check alone would miss.
	// Both counters are two-state and start at zero, so each has a single driver.
	always @(posedge pixel_clock_p) pixel_edges <= pixel_edges + 1;
	always @(posedge load_gated_c) shift_edges <= shift_edges + 1;
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the clock and load divider.
// Assumes the far-side model counts pixel clock and shift edges.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic clk, rst, sel_lsb, sel_msb, en_s, en_a, pr_n;
	logic pp, pn, la, lb, lh, lq, lc, ld;
	int pixel_edges, shift_edges, num_errors, checks_done, r;

	video_dac_clock_load_divider video_dac_clock_load_divider_i (.clk(clk), .rst(rst),
		.divide_select_lsb(sel_lsb), .divide_select_msb(sel_msb), .enable_sync(en_s),
		.enable_async(en_a), .pipe_reset_n(pr_n), .pixel_clock_p(pp), .pixel_clock_n(pn),
		.load_primary_a(la), .load_primary_b(lb), .load_half_rate(lh),
		.load_quarter_rate(lq), .load_gated_c(lc), .load_gated_d(ld));
	dac_side_model dac_side_model_i (.pixel_clock_p(pp), .load_gated_c(lc),
		.pixel_edges(pixel_edges), .shift_edges(shift_edges));

	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	function automatic int exp_ratio(input logic [1:0] s);
		return (s == 2'h3) ? 8 : 3 + s;
	endfunction

	function automatic int exp_high(input logic [1:0] s);
		return (s == 2'h3) ? 4 : ((s == 2'h2) ? 3 : 2);
	endfunction

	task automatic chk(input bit ok, input string what);
		checks_done++;
		if (!ok)
		begin
			num_errors++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask

	task automatic report_and_stop;
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic run(input logic [1:0] s, input bit tog);
		int la_t = -1, lh_t = -1, lq_t = -1, hi = 0, chi = -1, px0 = 0;
		logic pa, ph, pq, pc;
		@(negedge clk);
		{sel_msb, sel_lsb} = s;
		repeat (80) @(negedge clk);
		{pa, ph, pq, pc} = {la, lh, lq, lc};
		px0 = pixel_edges;
		for (int n = 0; n < 160; n++)
		begin
			@(negedge clk);
			if (tog) en_s = 1'($urandom_range(1, 0));
			// The pair follows clk through gates, so it is read once the falling edge settles.
			#1;
			chk(lb === la, "copy load differs");
			chk(pp === 1'b0 && pn === 1'b1, "clock pair wrong");
			if (tog)
				chk((la || !lc) && ld === lc, "gated load out of phase");
			else
				chk(lc === la && ld === la, "gated load differs");
			if (la && !pa && la_t >= 0) chk(n - la_t == exp_ratio(s), "load period");
			if (la && !pa) la_t = n;
			if (la && !pa) hi = 0;
			hi += la;
			if (!la && pa && la_t >= 0) chk(hi == exp_high(s), "load high time");
			if (lh && !ph && lh_t >= 0) chk(n - lh_t == 2 * exp_ratio(s), "half period");
			if (lh && !ph) lh_t = n;
			if (lq && !pq && lq_t >= 0) chk(n - lq_t == 4 * exp_ratio(s), "quarter period");
			if (lq && !pq) lq_t = n;
			if (lc && !pc) chi = 0;
			if (lc && chi >= 0) chi++;
			if (!lc && pc && chi >= 0) chk(chi == exp_high(s), "short gated pulse");
			{pa, ph, pq, pc} = {la, lh, lq, lc};
		end
		chk(pixel_edges - px0 == 160, "pixel clock rate");
		@(negedge clk);
		en_s = !tog;
		repeat (20) @(negedge clk);
		for (int n = 0; n < 20 && tog; n++)
		begin
			@(negedge clk);
			chk(lc === 1'b0 && ld === 1'b0, "gated load while closed");
		end
		en_s = 1;
	endtask

	task automatic freeze(input logic lvl);
		int sh;
		@(negedge clk);
		for (int k = 0; k < 30 && lc !== lvl; k++) @(negedge clk);
		en_a = 0;
		#1 chk(lc === lvl && ld === lvl, "freeze waited for a clock");
		sh = shift_edges;
		repeat (20)
		begin
			@(negedge clk);
			chk(lc === lvl && ld === lvl && shift_edges == sh, "gated load moved");
		end
		en_a = 1;
	endtask

	task automatic halt(input logic [1:0] s);
		int rises = 0, held = 0, px = 0;
		logic pq;
		@(negedge clk);
		{sel_msb, sel_lsb} = s;
		pr_n = 0;
		repeat (80) @(negedge clk);
		pq = lq;
		for (int k = 0; k < 40 && !(lq && !pq); k++)
		begin
			pq = lq;
			@(negedge clk);
		end
		// Released just after a quarter rise so the synchroniser delay cannot hide one.
		pr_n = 1;
		pq = lq;
		for (int n = 0; n < 12 * exp_ratio(s); n++)
		begin
			@(negedge clk);
			#1;
			if (lq && !pq) rises++;
			chk(pn === ~pp, "clock pair not complementary");
			if (pp && held == 0) chk(rises == 1 && lq && !pq, "halt start");
			if (pp && held == 0) px = pixel_edges;
			if (!pp && held > 0 && rises == 2 && lq && !pq)
				chk(pixel_edges == px, "pixel edges in halt");
			held += pp;
			pq = lq;
		end
		chk(held == 4 * exp_ratio(s) && rises == 3, "halt length");
		chk(pixel_edges - px == 4 * exp_ratio(s), "clock did not resume");
	endtask

	initial
	begin
		#300000;
		num_errors++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop;
	end

	initial
	begin
		num_errors = 0;
		checks_done = 0;
		{sel_msb, sel_lsb, en_s, en_a, pr_n} = 5'h07;
		rst = 1;
		r = $urandom(48283);
		repeat (16) @(negedge clk);
		chk({la, lh, lq, lc} === 4'h0, "reset levels");
		rst = 0;
		for (int i = 0; i < 4; i++) run(i[1:0], 0);
		for (int i = 0; i < 4; i++) run(2'($urandom_range(3, 0)), 1);
		freeze(1'b1);
		freeze(1'b0);
		run(2'($urandom_range(3, 0)), 0);
		for (int i = 0; i < 4; i++) halt(i[1:0]);
		report_and_stop;
	end
endmodule

`default_nettype wire
